// >>> verilog/wdhrc_defines.svh
// Register offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDHRC_DEFINES_SVH
`define WDHRC_DEFINES_SVH

`define WDHRC_PRESCALE_INDEX     8'h09
`define WDHRC_PRESCALE_ADDR      8'h24
`define WDHRC_STATUS_INDEX       8'h0a
`define WDHRC_STATUS_ADDR        8'h28
`define WDHRC_CTRL_ADDR          8'h40
`define WDHRC_INFO_ADDR          8'h44
`define WDHRC_PRESCALE_RESET     8'h07
`define WDHRC_PD_BIT             4
`define WDHRC_TO_BIT             5
`define WDHRC_CTRL_RESTART_BIT   0
`define WDHRC_CTRL_HALT_BIT      1
`define WDHRC_BASE_DIV_BITS      8
`define WDHRC_INSTR_DIV          4
`define WDHRC_STARTUP_CYCLES     1024
`define WDHRC_INTR_EXTRA_CYCLES  1
`define WDHRC_AXI_OKAY           2'b00
`define WDHRC_AXI_SLVERR         2'b10

`endif

// >>> verilog/wdhrc_pkg.sv
// Types shared by the watchdog, halt and reset control block
package wdhrc_pkg;

    typedef enum logic [2:0] {
        WDHRC_RESET   = 3'b000,
        WDHRC_STARTUP = 3'b001,
        WDHRC_RUN     = 3'b010,
        WDHRC_HALT    = 3'b011,
        WDHRC_WAKE    = 3'b100,
        WDHRC_EXTRA   = 3'b101
    } wdhrc_state_e;

    typedef enum logic [1:0] {
        WDHRC_WAKE_NONE = 2'b00,
        WDHRC_WAKE_PORT = 2'b01,
        WDHRC_WAKE_INTR = 2'b10,
        WDHRC_WAKE_WDT  = 2'b11
    } wdhrc_cause_e;

    typedef struct packed {
        logic chip_reset;
        logic warm_reset;
        logic resume_next;
        logic intr_vector;
    } wdhrc_cpu_ctl_s;

endpackage

// >>> verilog/wdhrc_top.sv
// Watchdog counter, halt mode, wake-up sequencing, reset-cause flags and start-up delay
//
// How it works
// - Watchdog clock: own oscillator or clock/4
// - Disabled watchdog makes every related action void
// - Oscillator source first divided by 256
// - Ratio field bits 2..0 divide by 2^n
// - Overflow in run: chip reset, set timeout
// - Overflow in halt: warm reset only
// - Pin low, restart or halt clears counter
// - Halt stops system clock; oscillator source keeps counting
// - Halt preserves memory, registers and ports
// - Halt sets power-down, clears timeout
// - Power-up and restart clear power-down flag
// - Wake on pin, interrupt, overflow, port edge
// - Port wake resumes at next instruction
// - Interrupt wake vectors if enabled, stack free
// - Wake waits 1024 clocks; vectored interrupt one more
// - Already pending interrupt cannot wake
// - Flags encode the reset cause
// - Chip reset initialises core and starts watchdog
// - Start-up delay after power-up, wake; not pin
// - Power-down bit 4, timeout bit 5
//
// Register access over AXI4-Lite was left to the implementer.
`include "wdhrc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module wdhrc_top #(
    parameter int          CLK_HZ         = 25000000,
    parameter logic        WDT_ENABLE     = 1'b1,
    parameter logic        WDT_USE_OSC    = 1'b1,
    parameter logic [7:0]  PA_WAKE_MASK   = 8'hff,
    parameter int          STARTUP_CYCLES = `WDHRC_STARTUP_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        wdt_osc_tick,
    input  wire logic        external_reset_pin_n,
    input  wire logic [7:0]  port_a_in,
    input  wire logic [2:0]  intr_req,
    input  wire logic [2:0]  intr_pending,
    input  wire logic        intr_enabled,
    input  wire logic        stack_full,
    input  wire logic        restart_instr,
    input  wire logic        halt_instr,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             cpu_run,
    output logic             sys_osc_en,
    output logic             chip_reset,
    output logic             warm_reset,
    output logic             resume_next,
    output logic             intr_vector
);

    localparam int SC_W = $clog2(STARTUP_CYCLES + 2);

    wdhrc_pkg::wdhrc_state_e   state_r;
    wdhrc_pkg::wdhrc_cause_e   cause_r;
    wdhrc_pkg::wdhrc_cpu_ctl_s ctl_r;
    logic [SC_W-1:0]           dly_r;
    logic [7:0]                prescale_r;
    logic                      to_flag_r;
    logic                      pd_flag_r;
    logic [1:0]                idiv_r;
    logic [`WDHRC_BASE_DIV_BITS-1:0] base_r;
    logic [7:0]                ratio_r;
    logic                      pin_r;
    logic [7:0]                pa_r;
    logic [2:0]                intr_mask_r;
    logic                      sw_restart_r;
    logic                      sw_halt_r;
    logic                      wdt_tick;
    logic                      base_wrap;
    logic [7:0]                ratio_lim;
    logic                      ratio_wrap;
    logic                      overflow;
    logic                      do_restart;
    logic                      do_halt;
    logic                      pin_low;
    logic                      pa_fall;
    logic                      intr_wake;

    // Register bus state
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;

    assign pin_low    = ~external_reset_pin_n;
    assign do_restart = WDT_ENABLE & (restart_instr | sw_restart_r) & (state_r == wdhrc_pkg::WDHRC_RUN);
    assign do_halt    = (halt_instr | sw_halt_r) & (state_r == wdhrc_pkg::WDHRC_RUN);
    assign pa_fall    = |(pa_r & ~port_a_in & PA_WAKE_MASK);
    assign intr_wake  = |(intr_req & ~intr_mask_r);

    // Instruction clock is system clock / 4, and it stops in halt
    assign wdt_tick = WDT_USE_OSC ? wdt_osc_tick
                    : ((idiv_r == 2'(`WDHRC_INSTR_DIV - 1)) && sys_osc_en);
    assign base_wrap  = wdt_tick & (&base_r);
    assign ratio_lim  = 8'((9'h001 << prescale_r[2:0]) - 9'h001);
    assign ratio_wrap = base_wrap & (ratio_r >= ratio_lim);
    assign overflow   = WDT_ENABLE & ratio_wrap;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idiv_r <= 2'h0;
        end else begin
            idiv_r <= idiv_r + 2'h1;
        end
    end

    // Counter runs only in run and halt; pin, restart and halt clear it
    always_ff @(posedge aclk) begin
        if (!aresetn || pin_low || do_restart || do_halt || !WDT_ENABLE) begin
            base_r  <= '0;
            ratio_r <= 8'h00;
        end else if (state_r == wdhrc_pkg::WDHRC_RUN || state_r == wdhrc_pkg::WDHRC_HALT) begin
            if (overflow) begin
                base_r  <= '0;
                ratio_r <= 8'h00;
            end else if (wdt_tick) begin
                base_r <= base_r + 1'b1;
                if (base_wrap) begin
                    ratio_r <= ratio_r + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_r <= 1'b1;
            pa_r  <= 8'hff;
        end else begin
            pin_r <= external_reset_pin_n;
            pa_r  <= port_a_in;
        end
    end

    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= wdhrc_pkg::WDHRC_STARTUP;
            cause_r     <= wdhrc_pkg::WDHRC_WAKE_NONE;
            dly_r       <= '0;
            intr_mask_r <= 3'h0;
            ctl_r       <= '{chip_reset: 1'b1, warm_reset: 1'b0,
                             resume_next: 1'b0, intr_vector: 1'b0};
        end else begin
            ctl_r <= '0;
            if (pin_low) begin
                state_r          <= wdhrc_pkg::WDHRC_RESET;
                ctl_r.chip_reset <= 1'b1;
            end else begin
                case (state_r)
                    wdhrc_pkg::WDHRC_RESET: begin
                        // Pin reset: no start-up delay
                        state_r <= wdhrc_pkg::WDHRC_RUN;
                    end
                    wdhrc_pkg::WDHRC_STARTUP: begin
                        ctl_r.chip_reset <= 1'b1;
                        dly_r <= dly_r + 1'b1;
                        if (dly_r == SC_W'(STARTUP_CYCLES - 1)) begin
                            dly_r   <= '0;
                            state_r <= wdhrc_pkg::WDHRC_RUN;
                        end
                    end
                    wdhrc_pkg::WDHRC_RUN: begin
                        if (overflow) begin
                            ctl_r.chip_reset <= 1'b1;
                        end else if (do_halt) begin
                            intr_mask_r <= intr_pending;
                            state_r     <= wdhrc_pkg::WDHRC_HALT;
                        end
                    end
                    wdhrc_pkg::WDHRC_HALT: begin
                        if (overflow) begin
                            cause_r <= wdhrc_pkg::WDHRC_WAKE_WDT;
                            state_r <= wdhrc_pkg::WDHRC_WAKE;
                        end else if (intr_wake) begin
                            cause_r <= wdhrc_pkg::WDHRC_WAKE_INTR;
                            state_r <= wdhrc_pkg::WDHRC_WAKE;
                        end else if (pa_fall) begin
                            cause_r <= wdhrc_pkg::WDHRC_WAKE_PORT;
                            state_r <= wdhrc_pkg::WDHRC_WAKE;
                        end
                    end
                    wdhrc_pkg::WDHRC_WAKE: begin
                        dly_r <= dly_r + 1'b1;
                        if (dly_r == SC_W'(STARTUP_CYCLES - 1)) begin
                            dly_r <= '0;
                            if (cause_r == wdhrc_pkg::WDHRC_WAKE_WDT) begin
                                ctl_r.warm_reset <= 1'b1;
                                state_r          <= wdhrc_pkg::WDHRC_RUN;
                            end else if (cause_r == wdhrc_pkg::WDHRC_WAKE_INTR
                                         && intr_enabled && !stack_full) begin
                                state_r <= wdhrc_pkg::WDHRC_EXTRA;
                            end else begin
                                ctl_r.resume_next <= 1'b1;
                                state_r           <= wdhrc_pkg::WDHRC_RUN;
                            end
                        end
                    end
                    wdhrc_pkg::WDHRC_EXTRA: begin
                        // One further cycle before the service routine
                        ctl_r.intr_vector <= 1'b1;
                        state_r           <= wdhrc_pkg::WDHRC_RUN;
                    end
                    default: begin
                        state_r <= wdhrc_pkg::WDHRC_RESET;
                    end
                endcase
            end
        end
    end

    // Flags; power-up gives 0,0 and a pin reset in run leaves them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_flag_r <= 1'b0;
            pd_flag_r <= 1'b0;
        end else if (pin_low && state_r == wdhrc_pkg::WDHRC_HALT) begin
            to_flag_r <= 1'b0;
            pd_flag_r <= 1'b1;
        end else if (overflow && state_r == wdhrc_pkg::WDHRC_RUN) begin
            to_flag_r <= 1'b1;
        end else if (state_r == wdhrc_pkg::WDHRC_HALT && overflow) begin
            to_flag_r <= 1'b1;
            pd_flag_r <= 1'b1;
        end else if (do_halt) begin
            to_flag_r <= 1'b0;
            pd_flag_r <= 1'b1;
        end else if (do_restart) begin
            to_flag_r <= 1'b0;
            pd_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_run     <= 1'b0;
            sys_osc_en  <= 1'b1;
            chip_reset  <= 1'b1;
            warm_reset  <= 1'b0;
            resume_next <= 1'b0;
            intr_vector <= 1'b0;
        end else begin
            cpu_run     <= (state_r == wdhrc_pkg::WDHRC_RUN) && !pin_low;
            sys_osc_en  <= (state_r != wdhrc_pkg::WDHRC_HALT) || pin_low;
            chip_reset  <= ctl_r.chip_reset;
            warm_reset  <= ctl_r.warm_reset;
            resume_next <= ctl_r.resume_next;
            intr_vector <= ctl_r.intr_vector;
        end
    end

    // AXI4-Lite write side: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WDHRC_AXI_OKAY;
            prescale_r   <= `WDHRC_PRESCALE_RESET;
            sw_restart_r <= 1'b0;
            sw_halt_r    <= 1'b0;
        end else begin
            sw_restart_r <= 1'b0;
            sw_halt_r    <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `WDHRC_AXI_OKAY;
                if (aw_addr_r[7:2] == `WDHRC_PRESCALE_ADDR >> 2) begin
                    if (w_strb_r[0]) begin
                        prescale_r <= w_data_r[7:0];
                    end
                end else if (aw_addr_r[7:2] == `WDHRC_CTRL_ADDR >> 2) begin
                    if (w_strb_r[0]) begin
                        sw_restart_r <= w_data_r[`WDHRC_CTRL_RESTART_BIT];
                        sw_halt_r    <= w_data_r[`WDHRC_CTRL_HALT_BIT];
                    end
                end else if (aw_addr_r[7:2] != `WDHRC_STATUS_ADDR >> 2) begin
                    s_axi_bresp <= `WDHRC_AXI_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (pin_low) begin
                prescale_r <= `WDHRC_PRESCALE_RESET;
            end
        end
    end

    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;

    // AXI4-Lite read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `WDHRC_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `WDHRC_AXI_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr[7:2] == `WDHRC_PRESCALE_ADDR >> 2) begin
                s_axi_rdata[7:0] <= prescale_r;
            end else if (s_axi_araddr[7:2] == `WDHRC_STATUS_ADDR >> 2) begin
                s_axi_rdata[`WDHRC_PD_BIT] <= pd_flag_r;
                s_axi_rdata[`WDHRC_TO_BIT] <= to_flag_r;
            end else if (s_axi_araddr[7:2] == `WDHRC_INFO_ADDR >> 2) begin
                s_axi_rdata[2:0] <= state_r;
                s_axi_rdata[5:4] <= cause_r;
            end else if (s_axi_araddr[7:2] != `WDHRC_CTRL_ADDR >> 2) begin
                s_axi_rresp <= `WDHRC_AXI_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

endmodule

`default_nettype wire

// >>> bench/wdhrc_top_asserts.sv
// Concurrent checks on the ports of the watchdog, halt and reset control block
`timescale 1ns/1ps
`default_nettype none

module wdhrc_top_asserts #(
    parameter int STARTUP_CYCLES = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic external_reset_pin_n,
    input wire logic intr_enabled,
    input wire logic stack_full,
    input wire logic halt_instr,
    input wire logic cpu_run,
    input wire logic sys_osc_en,
    input wire logic chip_reset,
    input wire logic warm_reset,
    input wire logic resume_next,
    input wire logic intr_vector
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Counts the wake delay only while the system clock runs, so halt time is not credited
    logic [15:0] wait_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || cpu_run || !sys_osc_en) begin
            wait_cnt <= 16'h0;
        end else begin
            wait_cnt <= wait_cnt + 16'h1;
        end
    end

    sequence s_halt_taken;
        cpu_run && halt_instr && external_reset_pin_n && !chip_reset;
    endsequence
    sequence s_osc_off;
        !sys_osc_en && !cpu_run;
    endsequence

    a_halt_stops_osc: assert property (s_halt_taken |-> ##2 s_osc_off)
        else $error("halt did not stop the system clock");
    a_pin_holds_reset: assert property (!external_reset_pin_n |=> !cpu_run ##1 chip_reset)
        else $error("reset pin low without chip reset");
    a_halt_no_run: assert property (!sys_osc_en |-> !cpu_run)
        else $error("core runs with clock stopped");
    a_resume_one_cycle: assert property ($rose(resume_next) |=> !resume_next)
        else $error("resume pulse too long");
    a_warm_one_cycle: assert property ($rose(warm_reset) |=> !warm_reset)
        else $error("warm reset pulse too long");
    a_wake_delay_len: assert property ((resume_next || warm_reset) |-> wait_cnt >= STARTUP_CYCLES - 2)
        else $error("wake delay too short");
    a_run_ovf_pulse: assert property (chip_reset && cpu_run && external_reset_pin_n |=> !chip_reset)
        else $error("run overflow reset not a pulse");
    a_vector_allowed: assert property (intr_vector |-> intr_enabled && !stack_full)
        else $error("vector taken while not allowed");
endmodule

bind wdhrc_top wdhrc_top_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_wdhrc_top_asserts (
    .aclk, .aresetn, .external_reset_pin_n, .intr_enabled, .stack_full, .halt_instr,
    .cpu_run, .sys_osc_en, .chip_reset, .warm_reset, .resume_next, .intr_vector);

`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the watchdog, halt and reset control block
`include "wdhrc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int          SC   = 16;
    localparam logic [31:0] PS_A = {24'h0, `WDHRC_PRESCALE_ADDR};
    localparam logic [31:0] ST_A = {24'h0, `WDHRC_STATUS_ADDR};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        wdt_osc_tick = 1'b1;
    logic        external_reset_pin_n = 1'b1;
    logic [7:0]  port_a_in = 8'hff;
    logic [2:0]  intr_req = 3'h0;
    logic [2:0]  intr_pending = 3'h0;
    logic        intr_enabled = 1'b1;
    logic        stack_full = 1'b0;
    logic        restart_instr = 1'b0;
    logic        halt_instr = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rd;
    logic        cpu_run, sys_osc_en, chip_reset, warm_reset, resume_next, intr_vector;
    logic        m_pd, m_to;
    int          errors = 0;
    int          num_checks = 0;
    int          n, k;

    always #20 aclk = ~aclk;

    wdhrc_top #(.PA_WAKE_MASK(8'h0f), .STARTUP_CYCLES(SC)) u_wdhrc_top (
        .aclk, .aresetn, .wdt_osc_tick, .external_reset_pin_n, .port_a_in, .intr_req,
        .intr_pending, .intr_enabled, .stack_full, .restart_instr, .halt_instr,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cpu_run, .sys_osc_en, .chip_reset, .warm_reset,
        .resume_next, .intr_vector);

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        num_checks++;
        if (v < lo || v > hi) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: pick = cpu_run;
            1: pick = resume_next;
            2: pick = warm_reset;
            3: pick = intr_vector;
            default: pick = chip_reset;
        endcase
    endfunction

    task automatic await(input int w, output int c);
        for (c = 1; c < 40000; c++) begin
            @(posedge aclk);
            if (pick(w) === 1'b1) break;
        end
    endtask

    task automatic pulse(input int w);
        @(posedge aclk);
        if (w == 0) restart_instr <= 1'b1;
        else halt_instr <= 1'b1;
        @(posedge aclk);
        restart_instr <= 1'b0;
        halt_instr <= 1'b0;
        // Restart and halt both clear the timeout flag
        m_pd = (w != 0);
        m_to = 1'b0;
    endtask

    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [31:0] a);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic stat;
        axr(ST_A);
        chk(rd, {26'h0, m_to, m_pd, 4'h0});
    endtask

    // Long enough for all eight ratios at one tick per cycle
    initial begin
        repeat (95000) @(posedge aclk);
        errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'hf01c6ce0));
        m_pd = 1'b0;
        m_to = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        await(0, n);
        rng(n, SC, SC + 3);
        axr(PS_A);
        chk(rd, 32'h7);
        stat();
        axr(32'h80);
        chk(rd, 32'h0);
        chk({30'h0, rr}, {30'h0, `WDHRC_AXI_SLVERR});
        axw(PS_A, 32'h0);
        pulse(0);
        pulse(1);
        await(2, n);
        rng(n, 256 + SC - 2, 256 + SC + 8);
        m_to = 1'b1;
        stat();
        axr(PS_A);
        chk(rd, 32'h0);
        await(0, n);
        axw(PS_A, 32'h7);
        pulse(0);
        pulse(1);
        repeat (3) @(posedge aclk);
        chk({31'h0, sys_osc_en}, 32'h0);
        stat();
        // Bit 7 is outside the wake mask, so this edge must not wake
        port_a_in <= 8'h7f;
        repeat (40) @(posedge aclk);
        chk({31'h0, cpu_run}, 32'h0);
        repeat ($urandom_range(2, 12)) @(posedge aclk);
        port_a_in <= 8'h7e;
        await(1, n);
        rng(n, SC, SC + 5);
        port_a_in <= 8'hff;
        stat();
        await(0, n);
        for (k = 0; k < 3; k++) begin
            intr_enabled <= (k != 2);
            stack_full <= (k == 1);
            pulse(1);
            repeat ($urandom_range(2, 12)) @(posedge aclk);
            intr_req <= 3'h1 << k;
            await(k == 0 ? 3 : 1, n);
            rng(n, SC + (k == 0 ? 1 : 0), SC + 6);
            intr_req <= 3'h0;
            await(0, n);
        end
        intr_pending <= 3'h4 | 3'($urandom_range(0, 3));
        pulse(1);
        intr_req <= 3'h4;
        repeat (40) @(posedge aclk);
        chk({31'h0, cpu_run}, 32'h0);
        intr_req <= 3'h0;
        intr_pending <= 3'h0;
        port_a_in <= 8'hfd;
        await(1, n);
        rng(n, SC, SC + 5);
        port_a_in <= 8'hff;
        await(0, n);
        for (k = 0; k < 8; k++) begin
            axw(PS_A, 32'(k));
            axr(PS_A);
            chk(rd, 32'(k));
            pulse(0);
            repeat (100) @(posedge aclk);
            pulse(0);
            await(4, n);
            rng(n, (256 << k) - 2, (256 << k) + 4);
            m_to = 1'b1;
            stat();
        end
        axw(PS_A, 32'h3);
        for (k = 0; k < 2; k++) begin
            if (k == 0) pulse(1);
            @(posedge aclk);
            external_reset_pin_n <= 1'b0;
            repeat (5) @(posedge aclk);
            chk({31'h0, chip_reset}, 32'h1);
            external_reset_pin_n <= 1'b1;
            await(0, n);
            rng(n, 1, 4);
            axr(PS_A);
            chk(rd, 32'h7);
            stat();
        end
        wrap_up();
    end
endmodule

`default_nettype wire
